// file: cfs_pkg.sv
//----------------------------------------------------------------------
// Summary of operation
// - Strap high at power-on, flag clear, selects pin-select mode
// - Strap low or floating selects serial bus
// - After sampling, strap pin drives reference output
// - Strap high, flag clear: pins index configs 0-3
// - Strap low: bus allowed, flag picks defaults/config0
// - Pin-select mode: power-up loads configuration chosen by select pins
// - Pin-select mode: select change reloads configuration within 1 ms
// - Source is crystal when bit equals pin
// - Pick pin polarity invertible by bus write
// - Primary-source bit is bit 1 of 0x13
// - Pin switchover only when mode upper bit 0
// - Source switching never glitches the output
//----------------------------------------------------------------------
package cfs_pkg;

   //----------------------------------------------------------------
   // Timing
   //----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int RELOAD_US = 1000;
   // Longest time, rounds down; exact at this rate
   localparam int RELOAD_CYC = RELOAD_US * CLK_MHZ;

   //----------------------------------------------------------------
   // Register map and fields
   //----------------------------------------------------------------
   localparam logic [7:0] REG_FLAGS_OFS = 8'h00;
   localparam logic [7:0] REG_SRC_OFS = 8'h13;
   localparam int FLAG_DEFSEL_BIT = 7;
   localparam int SRC_POL_BIT = 0;
   localparam int SRC_PRIM_BIT = 1;
   localparam int SRC_SM_HI_BIT = 3;

   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] src;
   } cfs_regs_t;

   localparam cfs_regs_t REGS_RST = '0;

   //----------------------------------------------------------------
   // Configuration store layout: word = bank * 2 + index
   //----------------------------------------------------------------
   localparam logic [2:0] BANK_BOOT = 3'h0;
   localparam logic [2:0] BANK_I2C_DEF = 3'h4;
   localparam logic IDX_FLAGS = 1'b0;
   localparam logic IDX_SRC = 1'b1;
   localparam int CFG_WORDS = 10;
   typedef logic [CFG_WORDS-1:0][7:0] cfs_image_t;
   localparam cfs_image_t CFG_IMAGE_DEF = {
      8'h00, 8'h80, 8'h08, 8'h00, 8'h01, 8'h00,
      8'h02, 8'h00, 8'h00, 8'h00};

   //----------------------------------------------------------------
   // Serial bus
   //----------------------------------------------------------------
   localparam logic [6:0] I2C_ADDR_DEF = 7'h6A;
   localparam logic [3:0] CNT_PRE = 4'hF;
   localparam logic [3:0] CNT_LAST = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h8;

   //----------------------------------------------------------------
   // State types
   //----------------------------------------------------------------
   typedef enum logic [2:0] {
      P_STRAP, P_FLAG, P_FLAGW, P_LDA, P_LDB, P_LDC, P_RUN
   } cfs_phase_t;

   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_PTR, I_WR, I_RD
   } cfs_i2c_t;

   typedef enum logic {M_RUN, M_ARM} cfs_mux_t;

   // Register read decode, unmapped offsets read zero
   function automatic logic [7:0] cfs_rd_byte(input cfs_regs_t r,
                                              input logic [7:0] ofs);
      logic [7:0] v;
      v = 8'h00;
      if (ofs == REG_FLAGS_OFS)
         v = r.flags;
      else if (ofs == REG_SRC_OFS)
         v = r.src;
      return v;
   endfunction : cfs_rd_byte

endpackage : cfs_pkg

// file: cfs_cfg_store.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Stored configuration banks, registered read
//----------------------------------------------------------------------
module cfs_cfg_store
   import cfs_pkg::*;
#(
   parameter cfs_image_t IMAGE = CFG_IMAGE_DEF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Read port
   input wire logic [2:0] bank,
   input wire logic idx,
   output logic [7:0] rdata
);

   logic [3:0] word;

   // Word address from bank and index
   assign word = {bank, idx};

   // Read data from a flop; out-of-range words read zero
   always_ff @(posedge clock) begin
      if (!rstn)
         rdata <= 8'h00;
      else if (word < 4'(CFG_WORDS))
         rdata <= IMAGE[word];
      else
         rdata <= 8'h00;
   end

endmodule : cfs_cfg_store

// file: cfs_ref_mux.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Glitch-free reference source switch
//----------------------------------------------------------------------
module cfs_ref_mux
   import cfs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Reference inputs
   input wire logic xtal_in,
   input wire logic diff_p,
   input wire logic diff_n,
   // Selection and result
   input wire logic want_diff,
   output logic clk_out,
   output logic active_diff
);

   cfs_mux_t mux_state_reg;
   logic src_cur;
   logic diff_bit;

   // Differential level as positive leg above negative
   assign diff_bit = diff_p & ~diff_n;
   assign src_cur = active_diff ? diff_bit : xtal_in;

   // Swap only while the old source is low, then wait for the new
   // one to be low too, so no shortened pulse reaches the output
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mux_state_reg <= M_RUN;
         active_diff <= 1'b0;
      end else begin
         case (mux_state_reg)
            M_RUN: begin
               if (want_diff != active_diff && !src_cur) begin
                  active_diff <= want_diff;
                  mux_state_reg <= M_ARM;
               end
            end
            M_ARM: begin
               if (!src_cur)
                  mux_state_reg <= M_RUN;
            end
            default: mux_state_reg <= M_RUN;
         endcase
      end
   end

   // Output parked low during the handover
   always_ff @(posedge clock) begin
      if (!rstn)
         clk_out <= 1'b0;
      else
         clk_out <= (mux_state_reg == M_RUN) ? src_cur : 1'b0;
   end

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   park_low_a: assert property (@(posedge clock) disable iff (!rstn)
      (mux_state_reg == M_ARM) |=> !clk_out)
      else $error("output not parked low during source swap");

   swap_on_low_a: assert property (@(posedge clock) disable iff (!rstn)
      $changed(active_diff) |-> !$past(src_cur) && !clk_out)
      else $error("source swapped while old source high");

   mux_swap_c: cover property (@(posedge clock) disable iff (!rstn)
      (mux_state_reg == M_ARM) ##1 (mux_state_reg == M_RUN));

endmodule : cfs_ref_mux

// file: cfs_top.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Configuration select and reference source control
//----------------------------------------------------------------------
module cfs_top
   import cfs_pkg::*;
#(
   parameter logic [6:0] I2C_ADDR = I2C_ADDR_DEF,
   parameter cfs_image_t IMAGE = CFG_IMAGE_DEF,
   parameter int RELOAD_MAX_CYC = RELOAD_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Strap pin, later reference output
   input wire logic strap_mode_pin_in,
   output logic strap_mode_pin_out,
   output logic strap_mode_pin_oe,
   // Shared select / serial bus pins
   input wire logic cfg_select_hi_in,
   output logic cfg_select_hi_out,
   output logic cfg_select_hi_oe,
   input wire logic cfg_select_lo_in,
   // Reference inputs
   input wire logic crystal_ref_input,
   input wire logic diff_ref_input_p,
   input wire logic diff_ref_input_n,
   input wire logic input_pick_pin,
   // Status
   output logic i2c_enabled,
   output logic load_busy,
   output logic [2:0] cfg_bank,
   output logic active_diff
);

   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   cfs_phase_t phase_reg;
   cfs_regs_t regs_reg;
   logic strap_reg;
   logic [1:0] sel_seen_reg;
   logic [2:0] bank_reg;
   logic [2:0] store_bank;
   logic store_idx;
   logic [7:0] store_rdata;
   logic [1:0] sel_now;
   logic sel_mode;
   logic reload_req;
   logic want_diff;
   logic manual_mode;
   logic mux_out;
   cfs_i2c_t i_state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic sda_oe_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic wr_commit;
   logic [7:0] rd_now;
   logic [7:0] rd_next;

   //-------------------------------------------------------------------
   // Power-up sequence and configuration load
   //-------------------------------------------------------------------
   assign sel_now = {cfg_select_hi_in, cfg_select_lo_in};
   // Pin-select mode needs the strap high and the default flag clear
   assign sel_mode = strap_reg && !regs_reg.flags[FLAG_DEFSEL_BIT];
   assign reload_req = (phase_reg == P_RUN) && sel_mode &&
                       (sel_now != sel_seen_reg);

   // Strap is caught once, on the first edge after reset release
   always_ff @(posedge clock) begin
      if (!rstn)
         strap_reg <= 1'b0;
      else if (phase_reg == P_STRAP)
         strap_reg <= strap_mode_pin_in;
   end

   // Load sequencer; store read data lags its address by one cycle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         phase_reg <= P_STRAP;
         bank_reg <= BANK_BOOT;
         sel_seen_reg <= 2'h0;
      end else begin
         case (phase_reg)
            P_STRAP: phase_reg <= P_FLAG;
            P_FLAG: phase_reg <= P_FLAGW;
            P_FLAGW: begin
               if (strap_reg && !store_rdata[FLAG_DEFSEL_BIT])
                  bank_reg <= {1'b0, sel_now};
               else if (!strap_reg && store_rdata[FLAG_DEFSEL_BIT])
                  bank_reg <= BANK_I2C_DEF;
               else
                  bank_reg <= BANK_BOOT;
               sel_seen_reg <= sel_now;
               phase_reg <= P_LDA;
            end
            P_LDA: phase_reg <= P_LDB;
            P_LDB: phase_reg <= P_LDC;
            P_LDC: phase_reg <= P_RUN;
            P_RUN: begin
               // Host keeps one pin moving at a time and waits out
               // the early window; any new code is simply reloaded
               if (reload_req) begin
                  bank_reg <= {1'b0, sel_now};
                  sel_seen_reg <= sel_now;
                  phase_reg <= P_LDA;
               end
            end
            default: phase_reg <= P_STRAP;
         endcase
      end
   end

   // Store address by phase
   always_comb begin
      store_bank = bank_reg;
      store_idx = IDX_FLAGS;
      if (phase_reg == P_FLAG)
         store_bank = BANK_BOOT;
      else if (phase_reg == P_LDB)
         store_idx = IDX_SRC;
   end

   cfs_cfg_store #(
      .IMAGE(IMAGE)
   ) u_store (
      .clock(clock),
      .rstn(rstn),
      .bank(store_bank),
      .idx(store_idx),
      .rdata(store_rdata)
   );

   //-------------------------------------------------------------------
   // Working registers
   //-------------------------------------------------------------------
   // Load beats a bus write; writes only happen in bus mode anyway
   always_ff @(posedge clock) begin
      if (!rstn) begin
         regs_reg <= REGS_RST;
      end else if (phase_reg == P_LDB) begin
         regs_reg.flags <= store_rdata;
      end else if (phase_reg == P_LDC) begin
         regs_reg.src <= store_rdata;
      end else if (wr_commit) begin
         if (ptr_reg == REG_FLAGS_OFS)
            regs_reg.flags <= shift_reg;
         else if (ptr_reg == REG_SRC_OFS)
            regs_reg.src <= shift_reg;
      end
   end

   //-------------------------------------------------------------------
   // Serial bus slave on the shared pins
   //-------------------------------------------------------------------
   // Bus only exists with the strap low, after capture
   assign i2c_enabled = !strap_reg && (phase_reg != P_STRAP);
   assign scl_rise = i2c_enabled && cfg_select_lo_in && !scl_d_reg;
   assign scl_fall = i2c_enabled && !cfg_select_lo_in && scl_d_reg;
   assign start_c = i2c_enabled && cfg_select_lo_in && scl_d_reg &&
                    sda_d_reg && !cfg_select_hi_in;
   assign stop_c = i2c_enabled && cfg_select_lo_in && scl_d_reg &&
                   !sda_d_reg && cfg_select_hi_in;
   assign wr_commit = scl_fall && (i_state_reg == I_WR) &&
                      (cnt_reg == CNT_LAST);
   assign rd_now = cfs_rd_byte(regs_reg, ptr_reg);
   assign rd_next = cfs_rd_byte(regs_reg, ptr_reg + 8'h01);

   // Previous pin levels for edge and start/stop detection
   always_ff @(posedge clock) begin
      if (!rstn) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= cfg_select_lo_in;
         sda_d_reg <= cfg_select_hi_in;
      end
   end

   // Bits sampled on rising clock, data driven after falling clock
   always_ff @(posedge clock) begin
      if (!rstn) begin
         i_state_reg <= I_IDLE;
         cnt_reg <= CNT_PRE;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         sda_oe_reg <= 1'b0;
      end else if (!i2c_enabled || stop_c) begin
         i_state_reg <= I_IDLE;
         sda_oe_reg <= 1'b0;
      end else if (start_c) begin
         i_state_reg <= I_ADDR;
         cnt_reg <= CNT_PRE;
         sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
         if (cnt_reg < CNT_ACK && i_state_reg != I_RD)
            shift_reg <= {shift_reg[6:0], cfg_select_hi_in};
         else if (cnt_reg == CNT_ACK && i_state_reg == I_RD &&
                  cfg_select_hi_in)
            i_state_reg <= I_IDLE; // Master ends the read
      end else if (scl_fall && i_state_reg != I_IDLE) begin
         if (cnt_reg == CNT_LAST) begin
            cnt_reg <= CNT_ACK;
            case (i_state_reg)
               I_ADDR: begin
                  if (shift_reg[7:1] == I2C_ADDR)
                     sda_oe_reg <= 1'b1;
                  else
                     i_state_reg <= I_IDLE;
               end
               I_PTR: begin
                  ptr_reg <= shift_reg;
                  sda_oe_reg <= 1'b1;
               end
               I_WR: sda_oe_reg <= 1'b1;
               default: sda_oe_reg <= 1'b0;
            endcase
         end else if (cnt_reg == CNT_ACK) begin
            cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            case (i_state_reg)
               I_ADDR: begin
                  if (shift_reg[0]) begin
                     i_state_reg <= I_RD;
                     tx_reg <= rd_now;
                     sda_oe_reg <= ~rd_now[7];
                  end else begin
                     i_state_reg <= I_PTR;
                  end
               end
               I_PTR: i_state_reg <= I_WR;
               I_WR: ptr_reg <= ptr_reg + 8'h01;
               I_RD: begin
                  ptr_reg <= ptr_reg + 8'h01;
                  tx_reg <= rd_next;
                  sda_oe_reg <= ~rd_next[7];
               end
               default: i_state_reg <= I_IDLE;
            endcase
         end else begin
            // Counter wraps from the pre-start value to bit 0
            cnt_reg <= cnt_reg + 4'h1;
            if (i_state_reg == I_RD) begin
               tx_reg <= {tx_reg[6:0], 1'b0};
               sda_oe_reg <= ~tx_reg[6];
            end
         end
      end
   end

   // Open-drain data line: only ever pulled low
   assign cfg_select_hi_out = 1'b0;
   assign cfg_select_hi_oe = sda_oe_reg;

   //-------------------------------------------------------------------
   // Reference source selection
   //-------------------------------------------------------------------
   // Outside manual mode the primary source stays on
   assign manual_mode = !regs_reg.src[SRC_SM_HI_BIT];
   assign want_diff = manual_mode ?
      (regs_reg.src[SRC_PRIM_BIT] ^
       input_pick_pin ^ regs_reg.src[SRC_POL_BIT]) :
      regs_reg.src[SRC_PRIM_BIT];

   cfs_ref_mux u_mux (
      .clock(clock),
      .rstn(rstn),
      .xtal_in(crystal_ref_input),
      .diff_p(diff_ref_input_p),
      .diff_n(diff_ref_input_n),
      .want_diff(want_diff),
      .clk_out(mux_out),
      .active_diff(active_diff)
   );

   //-------------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------------
   // Pin turns into an output once the strap has been taken
   always_ff @(posedge clock) begin
      if (!rstn)
         strap_mode_pin_oe <= 1'b0;
      else if (phase_reg == P_STRAP)
         strap_mode_pin_oe <= 1'b1;
   end

   assign strap_mode_pin_out = strap_mode_pin_oe & mux_out;
   assign load_busy = (phase_reg != P_RUN);
   assign cfg_bank = bank_reg;

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   strap_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      (phase_reg != P_STRAP) ##1 1'b1 |-> $stable(strap_reg))
      else $error("strap value changed after capture");

   pin_drive_a: assert property (@(posedge clock) disable iff (!rstn)
      (phase_reg != P_STRAP) |-> strap_mode_pin_oe &&
      (strap_mode_pin_out == mux_out))
      else $error("strap pin not driving reference output");

   bus_deny_a: assert property (@(posedge clock) disable iff (!rstn)
      strap_reg |-> !cfg_select_hi_oe && (i_state_reg == I_IDLE))
      else $error("serial bus active in pin-select mode");

   pin_bank_a: assert property (@(posedge clock) disable iff (!rstn)
      (phase_reg == P_FLAGW && strap_reg &&
       !store_rdata[FLAG_DEFSEL_BIT])
      |=> (bank_reg == {1'b0, $past(sel_now)}) ##3 (phase_reg == P_RUN))
      else $error("power-up bank not taken from select pins");

   bus_bank_a: assert property (@(posedge clock) disable iff (!rstn)
      (phase_reg == P_FLAGW && !strap_reg)
      |=> bank_reg == ($past(store_rdata[FLAG_DEFSEL_BIT]) ?
                       BANK_I2C_DEF : BANK_BOOT))
      else $error("bus-mode power-up bank wrong");

   reload_time_a: assert property (@(posedge clock) disable iff (!rstn)
      reload_req |=> (phase_reg != P_RUN) [*3] ##1
      (phase_reg == P_RUN) && (regs_reg.src == $past(store_rdata)))
      else $error("select change not reloaded in time");

   src_pick_a: assert property (@(posedge clock) disable iff (!rstn)
      (phase_reg == P_RUN && !regs_reg.src[SRC_SM_HI_BIT] &&
       !regs_reg.src[SRC_POL_BIT] &&
       (input_pick_pin == regs_reg.src[SRC_PRIM_BIT]))
      |-> !want_diff)
      else $error("equal bit and pin did not pick crystal");

   src_write_a: assert property (@(posedge clock) disable iff (!rstn)
      (wr_commit && ptr_reg == REG_SRC_OFS && phase_reg == P_RUN)
      |=> regs_reg.src == $past(shift_reg))
      else $error("source control write lost");

   addr_ack_a: assert property (@(posedge clock) disable iff (!rstn)
      (scl_fall && i_state_reg == I_ADDR && cnt_reg == CNT_LAST &&
       !start_c && !stop_c)
      |=> cfg_select_hi_oe == ($past(shift_reg[7:1]) == I2C_ADDR))
      else $error("address acknowledge wrong");

   reload_c: cover property (@(posedge clock) disable iff (!rstn)
      reload_req ##4 (phase_reg == P_RUN));

   bus_write_c: cover property (@(posedge clock) disable iff (!rstn)
      wr_commit && (ptr_reg == REG_SRC_OFS));

   defaults_c: cover property (@(posedge clock) disable iff (!rstn)
      (phase_reg == P_LDA) && (bank_reg == BANK_I2C_DEF));

endmodule : cfs_top

// file: cfs_host_model.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Board straps, select GPIOs and serial bus master
//----------------------------------------------------------------------
module cfs_host_model
   import cfs_pkg::*;
(
   // Clock
   input wire logic clock,
   // Device pin drivers
   input wire logic strap_out,
   input wire logic strap_oe,
   input wire logic sda_oe,
   // Resolved pin levels
   output logic strap_line,
   output logic hi_line,
   output logic lo_line
);
   logic strap_drv = 1'b0;
   logic hi_drv = 1'b1;
   logic lo_drv = 1'b1;

   // Strap resistor loses to the device once it drives the pin
   assign strap_line = strap_oe ? strap_out : strap_drv;
   // Open drain data line with board pull-up
   assign hi_line = sda_oe ? 1'b0 : hi_drv;
   assign lo_line = lo_drv;

   // Bus phases last four clocks, above the two-clock minimum
   task gap;
      repeat (4) @(negedge clock);
   endtask : gap

   // Data moves only while the bus clock is low
   task bit_io(input logic b, output logic s);
      hi_drv = b;
      gap;
      lo_drv = 1'b1;
      gap;
      s = hi_line;
      lo_drv = 1'b0;
   endtask : bit_io

   task start;
      hi_drv = 1'b1;
      gap;
      lo_drv = 1'b1;
      gap;
      hi_drv = 1'b0;
      gap;
      lo_drv = 1'b0;
      gap;
   endtask : start

   task stop;
      hi_drv = 1'b0;
      gap;
      lo_drv = 1'b1;
      gap;
      hi_drv = 1'b1;
      gap;
   endtask : stop

   // MSB first byte, then the acknowledge bit
   task xfer(input logic [7:0] d, input logic m_ack,
             output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(m_ack, ack);
   endtask : xfer

endmodule : cfs_host_model

// file: cfs_top_bench.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Self-checking bench
//----------------------------------------------------------------------
module cfs_top_bench;
   import cfs_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic pick = 1'b0;
   logic [1:0] ref_cnt = 2'h0;
   logic s_out, s_oe, sda_oe, strap_line, hi_line, lo_line;
   logic i2c_en, busy, adiff;
   logic [2:0] bank;
   // Boot word with the default-select flag set
   localparam cfs_image_t IMG_FLAG = {
      8'h00, 8'h80, 8'h08, 8'h00, 8'h01, 8'h00,
      8'h02, 8'h00, 8'h00, 8'h80};
   logic i2c_en_f;
   logic [2:0] bank_f;
   logic [7:0] q;
   logic a;
   int mismatches = 0;
   int n_checks = 0;

   initial begin
      forever #20 clock = ~clock;
   end

   // References toggle fast so the switch finds low phases soon
   always @(negedge clock) ref_cnt <= ref_cnt + 2'h1;

   cfs_host_model p (.clock(clock), .strap_out(s_out), .strap_oe(s_oe),
      .sda_oe(sda_oe), .strap_line(strap_line), .hi_line(hi_line),
      .lo_line(lo_line));

   cfs_top DUT (.clock(clock), .rstn(rstn),
      .strap_mode_pin_in(strap_line), .strap_mode_pin_out(s_out),
      .strap_mode_pin_oe(s_oe), .cfg_select_hi_in(hi_line),
      .cfg_select_hi_out(), .cfg_select_hi_oe(sda_oe),
      .cfg_select_lo_in(lo_line), .crystal_ref_input(ref_cnt[0]),
      .diff_ref_input_p(ref_cnt[1]), .diff_ref_input_n(~ref_cnt[1]),
      .input_pick_pin(pick), .i2c_enabled(i2c_en), .load_busy(busy),
      .cfg_bank(bank), .active_diff(adiff));

   // Twin with the flag set; it only listens, its ack stays off the bus
   cfs_top #(.IMAGE(IMG_FLAG)) DUT_FLAG (.clock(clock), .rstn(rstn),
      .strap_mode_pin_in(strap_line), .strap_mode_pin_out(),
      .strap_mode_pin_oe(), .cfg_select_hi_in(hi_line),
      .cfg_select_hi_out(), .cfg_select_hi_oe(),
      .cfg_select_lo_in(lo_line), .crystal_ref_input(ref_cnt[0]),
      .diff_ref_input_p(ref_cnt[1]), .diff_ref_input_n(~ref_cnt[1]),
      .input_pick_pin(pick), .i2c_enabled(i2c_en_f), .load_busy(),
      .cfg_bank(bank_f), .active_diff());

   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // Straps settle during reset, as they ramp with the supply
   task rst(input logic st, input logic hi, input logic lo);
      rstn = 1'b0;
      p.strap_drv = st;
      p.hi_drv = hi;
      p.lo_drv = lo;
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      repeat (10) @(negedge clock);
   endtask : rst

   task wr(input logic [7:0] ofs, input logic [7:0] d);
      p.start;
      p.xfer({I2C_ADDR_DEF, 1'b0}, 1'b1, q, a);
      check(8'(a), 8'h00);
      p.xfer(ofs, 1'b1, q, a);
      p.xfer(d, 1'b1, q, a);
      check(8'(a), 8'h00);
      p.stop;
   endtask : wr

   task rd(input logic [7:0] ofs, input logic [7:0] exp);
      p.start;
      p.xfer({I2C_ADDR_DEF, 1'b0}, 1'b1, q, a);
      p.xfer(ofs, 1'b1, q, a);
      p.start;
      p.xfer({I2C_ADDR_DEF, 1'b1}, 1'b1, q, a);
      p.xfer(8'hFF, 1'b1, q, a);
      check(q, exp);
      p.stop;
   endtask : rd

   // Pin mode: power-up pick, one-pin reload, pin-side source choice
   task t_pins;
      int n;
      logic e;
      rst(1'b1, 1'b1, 1'b0);
      check(8'(bank), 8'h02);
      check(8'(i2c_en), 8'h00);
      check(8'(s_oe), 8'h01);
      check(8'(adiff), 8'h01);
      check(8'(bank_f), 8'h00);
      p.strap_drv = 1'b0;
      repeat (200) @(negedge clock);
      // Strap pin now carries the differential reference, one clock late
      @(posedge clock);
      e = ref_cnt[1];
      @(negedge clock);
      check(8'(s_out), 8'(e));
      p.lo_drv = 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      while (busy !== 1'b0 && n < RELOAD_CYC + 10) begin
         @(negedge clock);
         n++;
      end
      check(8'(n <= RELOAD_CYC), 8'h01);
      check(8'(bank), 8'h03);
      check(8'(bank_f), 8'h00);
      repeat (20) @(negedge clock);
      check(8'(adiff), 8'h00);
      check(8'(i2c_en), 8'h00);
   endtask : t_pins

   // Bus mode: register access and source selection by register
   task t_bus;
      rst(1'b0, 1'b1, 1'b1);
      check(8'(i2c_en), 8'h01);
      check(8'(bank), 8'h00);
      check(8'(bank_f), 8'h04);
      check(8'(i2c_en_f), 8'h01);
      rd(8'h13, 8'h00);
      wr(8'h13, 8'h02);
      repeat (20) @(negedge clock);
      check(8'(adiff), 8'h01);
      rd(8'h13, 8'h02);
      pick = 1'b1;
      repeat (20) @(negedge clock);
      check(8'(adiff), 8'h00);
      wr(8'h13, 8'h03);
      repeat (20) @(negedge clock);
      check(8'(adiff), 8'h01);
      wr(8'h05, 8'h5A);
      rd(8'h05, 8'h00);
   endtask : t_bus

   initial begin
      t_pins;
      t_bus;
      results;
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clock);
      mismatches++;
      results;
   end

endmodule : cfs_top_bench
